//--- verilog/adcrd_pkg.sv
// Constants and types shared by both ends of the converter readout link
package adcrd_pkg;

	// ------------------------------------------------------------------
	// Timing base
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned RES_BITS      = 14;
	localparam int unsigned CNT_W         = 8;

	// Conversion window, in ns and in clk cycles
	localparam int unsigned T_CONV_MIN_NS = 1000;
	localparam int unsigned T_CONV_MAX_NS = 2500;
	localparam logic [7:0]  CONV_MIN_CYC  =
		8'((T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  CONV_MAX_CYC  =
		8'(T_CONV_MAX_NS / CLK_PERIOD_NS);

	// ------------------------------------------------------------------
	// Readout framing
	// ------------------------------------------------------------------
	localparam logic [4:0]  WORD_PLAIN    = 5'h0e;
	localparam logic [4:0]  WORD_BUSY     = 5'h0f;
	localparam logic [4:0]  SCK_CNT_MAX   = 5'h1f;
	localparam logic [3:0]  MSB_IDX       = 4'hd;

	// Host side pacing, in clk cycles
	localparam logic [7:0]  SCK_HALF_CYC  = 8'h04;
	localparam logic [7:0]  SETUP_CYC     = 8'h02;
	localparam logic [7:0]  HOLD_CYC      = 8'h04;
	localparam logic [7:0]  WAIT_PAD_CYC  = 8'h04;

	// ------------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ADCRD_IDLE = 2'h0,
		ADCRD_CONV = 2'h1,
		ADCRD_ACQ  = 2'h3
	} adcrd_dev_state_t;

	typedef enum logic [2:0] {
		ADCRD_H_IDLE  = 3'h0,
		ADCRD_H_SETUP = 3'h1,
		ADCRD_H_CONV  = 3'h3,
		ADCRD_H_READ  = 3'h2,
		ADCRD_H_DONE  = 3'h6
	} adcrd_host_state_t;

endpackage

//--- verilog/adcrd_if.sv
// Link wires between the converter end and the host end
`timescale 1ns/1ps
`default_nettype none

interface adcrd_if;
	logic convert_start;
	logic serial_in_select;
	logic sclk;
	logic serial_out_o;
	logic serial_out_oe_n;
	logic serial_out;

	// Pull-up on the data line: released line reads high
	assign serial_out = serial_out_oe_n ? 1'b1 : serial_out_o;

	modport dev (
		input  convert_start,
		input  serial_in_select,
		input  sclk,
		output serial_out_o,
		output serial_out_oe_n
	);

	modport host (
		output convert_start,
		output serial_in_select,
		output sclk,
		input  serial_out
	);
endinterface

`default_nettype wire

//--- verilog/adcrd_device.sv
// Converter end: conversion timer, mode capture and serial result shifter
//
// Notes on behaviour
// - Select mode start tristates output
// - Start held high; both low drives low
// - Host frees select line after its last bit
// - No busy: select low shows MSB
// - No busy: release at 14th fall
// - Busy wanted: host holds select low
// - Busy select: drive low at completion
// - Busy select: release at 15th fall
// - Bit held across the rising clock edge
// - Host keeps overlapping selects brief
// - Clock low at start: chain, no busy
// - Chain no busy: MSB at completion
// - Chain: select input feeds shifter
// - Host: fourteen clocks per chained device
// - Host: plus one clock with busy
// - Clock high at start: chain busy
// - Chain busy: drive high when done
// - Completion enters acquisition, powers down
// - Select level at start picks mode
`timescale 1ns/1ps
`default_nettype none

module adcrd_device
	import adcrd_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst,
	adcrd_if.dev                     link,
	input  wire logic [RES_BITS-1:0] sample_code,
	output logic                     converting,
	output logic                     acquiring,
	output logic                     chain_mode,
	output logic                     busy_enabled
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0]            sync1_q;
	logic [2:0]            sync2_q;
	logic                  cnv_prev_q;
	logic                  cnv_s;
	logic                  sel_s;
	logic                  sck_s;
	logic                  cnv_rise;

	// Start, select and clock levels into the timer domain
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {link.convert_start, link.serial_in_select, link.sclk};
			sync2_q <= sync1_q;
		end
	end

	assign cnv_s    = sync2_q[2];
	assign sel_s    = sync2_q[1];
	assign sck_s    = sync2_q[0];
	assign cnv_rise = cnv_s & ~cnv_prev_q;

	// Edge detector looks only at the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			cnv_prev_q <= 1'b0;
		end else begin
			cnv_prev_q <= cnv_s;
		end
	end

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	adcrd_dev_state_t      state_q;
	adcrd_dev_state_t      state_d;
	logic [CNT_W-1:0]      tmr_q;
	logic                  conv_end;
	logic                  arm_q;

	assign conv_end = (state_q == ADCRD_CONV) && (tmr_q == CONV_MAX_CYC - 8'h01);

	// A start edge during a conversion is ignored: it runs to the end
	always_comb begin
		state_d = state_q;
		case (state_q)
			ADCRD_IDLE: begin
				if (cnv_rise) begin
					state_d = ADCRD_CONV;
				end
			end
			ADCRD_CONV: begin
				if (conv_end) begin
					state_d = ADCRD_ACQ;
				end
			end
			ADCRD_ACQ: begin
				if (cnv_rise) begin
					state_d = ADCRD_CONV;
				end
			end
			default: begin
				state_d = ADCRD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ADCRD_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Conversion timer; restarts on every accepted start edge
	always_ff @(posedge clk) begin
		if (rst) begin
			tmr_q <= 8'h00;
		end else if (state_d == ADCRD_CONV && state_q != ADCRD_CONV) begin
			tmr_q <= 8'h00;
		end else if (state_q == ADCRD_CONV) begin
			tmr_q <= tmr_q + 8'h01;
		end
	end

	// Shifter runs only in acquisition; a clean flop avoids decode glitches
	always_ff @(posedge clk) begin
		if (rst) begin
			arm_q <= 1'b0;
		end else begin
			arm_q <= (state_d == ADCRD_ACQ);
		end
	end

	// ------------------------------------------------------------------
	// Mode capture and result
	// ------------------------------------------------------------------
	logic                  chain_q;
	logic                  busy_q;
	logic [RES_BITS-1:0]   hold_q;
	logic [RES_BITS-1:0]   result_q;

	// Mode and sample taken at the accepted start edge
	always_ff @(posedge clk) begin
		if (rst) begin
			chain_q <= 1'b0;
			hold_q  <= 14'h0000;
		end else if (cnv_rise && state_q != ADCRD_CONV) begin
			chain_q <= ~sel_s;
			hold_q  <= sample_code;
		end
	end

	// Chain decides busy at start; select mode decides at the end
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else if (cnv_rise && state_q != ADCRD_CONV) begin
			busy_q <= ~sel_s & sck_s;
		end else if (conv_end && !chain_q) begin
			busy_q <= ~sel_s | ~cnv_s;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			result_q <= 14'h0000;
		end else if (conv_end) begin
			result_q <= hold_q;
		end
	end

	// ------------------------------------------------------------------
	// Link side shifter, clocked by falling serial clock edges
	// ------------------------------------------------------------------
	logic [4:0]            cnt_q;
	logic [RES_BITS-1:0]   cap_q;
	logic                  shift_en;

	// Mode flags are static while armed, so reading them here is safe
	assign shift_en = chain_q | ~link.serial_in_select;

	always_ff @(negedge link.sclk or negedge arm_q) begin
		if (!arm_q) begin
			cnt_q <= 5'h00;
		end else if (shift_en && cnt_q != SCK_CNT_MAX) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	// With busy the first fall only drops the head bit
	always_ff @(negedge link.sclk or negedge arm_q) begin
		if (!arm_q) begin
			cap_q <= 14'h0000;
		end else if (chain_q && !(busy_q && cnt_q == 5'h00)) begin
			cap_q <= {cap_q[RES_BITS-2:0], link.serial_in_select};
		end
	end

	// ------------------------------------------------------------------
	// Output selection
	// ------------------------------------------------------------------
	logic [4:0]            word_len;
	logic [4:0]            pos;
	logic [4:0]            idx;
	logic                  data_bit;
	logic                  drv;
	logic                  out_bit;

	assign word_len = busy_q ? WORD_BUSY : WORD_PLAIN;

	// Bit changes only on falls, so it stands over the next rise too
	always_comb begin
		pos      = busy_q ? cnt_q - 5'h01 : cnt_q;
		idx      = {1'b0, MSB_IDX} - pos;
		data_bit = result_q[idx[3:0]];
		if (busy_q && cnt_q == 5'h00) begin
			data_bit = chain_q;
		end else if (cnt_q >= word_len) begin
			data_bit = cap_q[RES_BITS-1];
		end
	end

	// Whole-line drive decision
	always_comb begin
		drv     = 1'b0;
		out_bit = 1'b0;
		if (!cnv_s && !sel_s) begin
			drv = 1'b1;
		end else begin
			case (state_q)
				ADCRD_CONV: begin
					drv = chain_q;
				end
				ADCRD_ACQ: begin
					if (chain_q) begin
						drv     = 1'b1;
						out_bit = data_bit;
					end else if (!sel_s && cnt_q < word_len) begin
						drv     = 1'b1;
						out_bit = data_bit;
					end
				end
				default: begin
					drv = 1'b0;
				end
			endcase
		end
	end

	assign link.serial_out_o    = out_bit;
	assign link.serial_out_oe_n = ~drv;

	// Status levels for the user side
	assign converting   = (state_q == ADCRD_CONV);
	assign acquiring    = (state_q == ADCRD_ACQ);
	assign chain_mode   = chain_q;
	assign busy_enabled = busy_q;

endmodule // adcrd_device

`default_nettype wire

//--- verilog/adcrd_host.sv
// Host end: starts conversions, makes the serial clock, collects bits
`timescale 1ns/1ps
`default_nettype none

module adcrd_host
	import adcrd_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	adcrd_if.host           link,
	input  wire logic       start,
	input  wire logic       chain_sel,
	input  wire logic       busy_sel,
	input  wire logic [7:0] bit_count,
	output logic            busy,
	output logic            rx_bit,
	output logic            rx_valid,
	output logic            done
);

	// ------------------------------------------------------------------
	// Data line synchroniser
	// ------------------------------------------------------------------
	logic                   sdo1_q;
	logic                   sdo2_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			sdo1_q <= 1'b1;
			sdo2_q <= 1'b1;
		end else begin
			sdo1_q <= link.serial_out;
			sdo2_q <= sdo1_q;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	adcrd_host_state_t      st_q;
	logic [7:0]             tmr_q;
	logic [7:0]             n_q;
	logic [7:0]             bits_q;
	logic                   chain_q;
	logic                   busym_q;
	logic                   cnv_q;
	logic                   sel_q;
	logic                   sck_q;
	logic                   ready;
	logic                   half;

	// Indicator seen, or the worst case conversion time has passed
	always_comb begin
		if (!busym_q) begin
			ready = tmr_q >= CONV_MAX_CYC + WAIT_PAD_CYC;
		end else begin
			ready = tmr_q >= CONV_MIN_CYC && (sdo2_q == chain_q);
		end
	end

	assign half = (tmr_q == SCK_HALF_CYC - 8'h01);

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q     <= ADCRD_H_IDLE;
			tmr_q    <= 8'h00;
			n_q      <= 8'h00;
			bits_q   <= 8'h00;
			chain_q  <= 1'b0;
			busym_q  <= 1'b0;
			cnv_q    <= 1'b0;
			sel_q    <= 1'b1;
			sck_q    <= 1'b0;
			rx_bit   <= 1'b0;
			rx_valid <= 1'b0;
			done     <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			done     <= 1'b0;
			tmr_q    <= tmr_q + 8'h01;
			case (st_q)
				ADCRD_H_IDLE: begin
					tmr_q <= 8'h00;
					if (start) begin
						chain_q <= chain_sel;
						busym_q <= busy_sel;
						n_q     <= bit_count;
						sel_q   <= ~chain_sel;
						sck_q   <= chain_sel & busy_sel;
						st_q    <= ADCRD_H_SETUP;
					end
				end
				ADCRD_H_SETUP: begin
					if (tmr_q == SETUP_CYC) begin
						cnv_q <= 1'b1;
						tmr_q <= 8'h00;
						st_q  <= ADCRD_H_CONV;
					end
				end
				ADCRD_H_CONV: begin
					// Clock level and select stand past the start edge
					if (tmr_q == HOLD_CYC) begin
						sck_q <= 1'b0;
						if (busym_q && !chain_q) begin
							sel_q <= 1'b0;
						end
					end
					if (ready) begin
						if (!chain_q) begin
							sel_q <= 1'b0;
						end
						// Select needs a trip through both synchronisers
						// before the MSB reaches sdo2_q, so start early
						tmr_q  <= 8'h00 - SETUP_CYC;
						bits_q <= 8'h00;
						st_q   <= ADCRD_H_READ;
					end
				end
				ADCRD_H_READ: begin
					// Sample on the rise, the device moves on the fall
					if (half) begin
						tmr_q <= 8'h00;
						if (!sck_q) begin
							sck_q    <= 1'b1;
							rx_bit   <= sdo2_q;
							rx_valid <= 1'b1;
							bits_q   <= bits_q + 8'h01;
						end else begin
							sck_q <= 1'b0;
							if (bits_q == n_q) begin
								st_q <= ADCRD_H_DONE;
							end
						end
					end
				end
				ADCRD_H_DONE: begin
					sel_q <= ~chain_q;
					cnv_q <= 1'b0;
					done  <= 1'b1;
					st_q  <= ADCRD_H_IDLE;
				end
				default: begin
					st_q <= ADCRD_H_IDLE;
				end
			endcase
		end
	end

	assign busy                  = (st_q != ADCRD_H_IDLE);
	assign link.convert_start    = cnv_q;
	assign link.serial_in_select = sel_q;
	assign link.sclk             = sck_q;

endmodule // adcrd_host

`default_nettype wire

//--- dv/adcrd_props.sv
// Concurrent checks on the converter readout link wires
`timescale 1ns/1ps
`default_nettype none

module adcrd_props (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic convert_start,
	input  wire logic serial_in_select,
	input  wire logic sclk,
	input  wire logic serial_out_o,
	input  wire logic serial_out_oe_n,
	input  wire logic serial_out
);
	// ------------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------------
	logic [7:0] cyc_q;
	logic [4:0] fall_q;
	logic       sel_q;
	logic       busy_q;
	logic       cbusy_q;

	// Counts since start; idle value 0xff keeps timed checks quiet
	always_ff @(posedge clk) begin
		if (rst) begin
			cyc_q  <= 8'hff;
			fall_q <= 5'h00;
		end else if ($rose(convert_start)) begin
			cyc_q  <= 8'h00;
			fall_q <= 5'h00;
		end else begin
			if (cyc_q != 8'hff)
				cyc_q <= cyc_q + 8'h01;
			// Early falls belong to the start strobe, not readout
			if ($fell(sclk) && cyc_q >= 8'h0a && fall_q != 5'h1f)
				fall_q <= fall_q + 5'h01;
		end
	end

	// Mode seen at start; select level late in conversion marks busy
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_q   <= 1'b1;
			busy_q  <= 1'b0;
			cbusy_q <= 1'b0;
		end else if ($rose(convert_start)) begin
			sel_q   <= serial_in_select;
			cbusy_q <= !serial_in_select && sclk;
		end else if (cyc_q == 8'h14) begin
			busy_q  <= !serial_in_select;
		end
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence conv_mid;
		cyc_q == 8'h14;
	endsequence

	sequence head_slot;
		cyc_q == 8'h1f && fall_q == 5'h00;
	endsequence

	start_hiz_a: assert property (
		$rose(convert_start) && serial_in_select |->
		##4 serial_out_oe_n [*8]) else $error("output not released");
	both_low_a: assert property (
		(!convert_start && !serial_in_select) [*3] |->
		!serial_out_oe_n && !serial_out_o) else $error("not driven low");
	sel_rise_a: assert property (
		sel_q && $rose(serial_in_select) |-> ##3 serial_out_oe_n)
		else $error("kept driving after deselect");
	// Start drops right after the last fall, so it cannot qualify here;
	// one cycle on, deselect has not yet reached the converter
	end_plain_a: assert property (
		sel_q && !busy_q && $changed(fall_q) && fall_q == 5'h0e |->
		##1 serial_out_oe_n) else $error("no release after 14 falls");
	end_busy_a: assert property (
		sel_q && busy_q && $changed(fall_q) && fall_q == 5'h0f |->
		##1 serial_out_oe_n) else $error("no release after 15 falls");
	conv_hiz_a: assert property (
		sel_q and conv_mid |-> serial_out_oe_n)
		else $error("driven during conversion");
	sel_head_a: assert property (
		sel_q && busy_q and head_slot |-> !serial_out_oe_n && !serial_out_o)
		else $error("busy start bit missing");
	chain_low_a: assert property (
		!sel_q and conv_mid |-> !serial_out_oe_n && !serial_out_o)
		else $error("chain output not low in conversion");
	chain_head_a: assert property (
		!sel_q && cbusy_q and head_slot |-> !serial_out_oe_n && serial_out_o)
		else $error("chain busy flag missing");
	bit_hold_a: assert property (
		$rose(sclk) && convert_start && cyc_q > 8'h1e |->
		##2 $stable(serial_out) [*2]) else $error("bit moved at rise");
endmodule // adcrd_props

`default_nettype wire

//--- dv/tb_adcrd_serial_readout_chain.sv
// Self-checking bench joining host end and converter end
`timescale 1ns/1ps
`default_nettype none

module tb_adcrd_serial_readout_chain;
	// ------------------------------------------------------------------
	// Stimulus and wiring
	// ------------------------------------------------------------------
	logic        clk;
	logic        rst;
	logic        start;
	logic        chain_sel;
	logic        busy_sel;
	logic [7:0]  bit_count;
	logic [13:0] code;
	logic        busy;
	logic        rx_bit;
	logic        rx_valid;
	logic        done;
	logic        converting;
	logic        acquiring;
	logic        chain_mode;
	logic        busy_enabled;
	int          err_total;
	int          n_checks;

	adcrd_if u_adcrd_if ();

	adcrd_host u_adcrd_host (.clk(clk), .rst(rst), .link(u_adcrd_if),
		.start(start), .chain_sel(chain_sel), .busy_sel(busy_sel),
		.bit_count(bit_count), .busy(busy), .rx_bit(rx_bit),
		.rx_valid(rx_valid), .done(done));

	adcrd_device u_adcrd_device (.clk(clk), .rst(rst), .link(u_adcrd_if),
		.sample_code(code), .converting(converting),
		.acquiring(acquiring), .chain_mode(chain_mode),
		.busy_enabled(busy_enabled));

	adcrd_props u_adcrd_props (.clk(clk), .rst(rst),
		.convert_start(u_adcrd_if.convert_start),
		.serial_in_select(u_adcrd_if.serial_in_select),
		.sclk(u_adcrd_if.sclk), .serial_out_o(u_adcrd_if.serial_out_o),
		.serial_out_oe_n(u_adcrd_if.serial_out_oe_n),
		.serial_out(u_adcrd_if.serial_out));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic stop_test;
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic chk_flag(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %b got %b", what, exp, got);
		end
	endtask

	// One conversion plus readout; bits gathered in wire order
	task automatic xfer(input logic c, input logic b, input logic [7:0] n,
		input logic [13:0] v, output logic [31:0] w);
		int i;
		int ncv;
		w   = 32'h0;
		ncv = 0;
		@(posedge clk);
		chain_sel <= c;
		busy_sel  <= b;
		bit_count <= n;
		code      <= v;
		start     <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		// Sample on the falling edge so register updates have landed
		for (i = 0; i < 1000; i++) begin
			@(negedge clk);
			if (rx_valid === 1'b1)
				w = {w[30:0], rx_bit};
			if (converting === 1'b1)
				ncv++;
			if (done === 1'b1)
				break;
		end
		chk_flag("done", 1'b1, done);
		chk_flag("acquiring", 1'b1, acquiring);
		chk_flag("converting", 1'b0, converting);
		chk_flag("host idle", 1'b0, busy);
		chk_word("conv cycles", {24'h0, adcrd_pkg::CONV_MAX_CYC}, ncv);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic sc_sel_plain;
		logic [31:0] w;
		xfer(1'b0, 1'b0, 8'h0e, 14'h2aaa, w);
		chk_word("sel word", 32'h00002aaa, w);
		chk_flag("sel mode", 1'b0, chain_mode);
		chk_flag("sel busy", 1'b0, busy_enabled);
	endtask

	// Deselect after five bits cuts the word short
	task automatic sc_sel_short;
		logic [31:0] w;
		xfer(1'b0, 1'b0, 8'h05, 14'h1a5c, w);
		chk_word("sel short", 32'h0000000d, w);
	endtask

	task automatic sc_sel_busy;
		logic [31:0] w;
		xfer(1'b0, 1'b1, 8'h0f, 14'h1555, w);
		chk_word("sel busy word", 32'h00001555, w);
		chk_flag("sel busy on", 1'b1, busy_enabled);
	endtask

	// Two words long: own result then the zeros shifted in
	task automatic sc_chain_plain;
		logic [31:0] w;
		xfer(1'b1, 1'b0, 8'h1c, 14'h3fff, w);
		chk_word("chain word", 32'h0fffc000, w);
		chk_flag("chain mode", 1'b1, chain_mode);
		chk_flag("chain busy", 1'b0, busy_enabled);
	endtask

	task automatic sc_chain_busy;
		logic [31:0] w;
		xfer(1'b1, 1'b1, 8'h0f, 14'h0001, w);
		chk_word("chain busy word", 32'h00004001, w);
		chk_flag("chain busy mode", 1'b1, chain_mode);
		chk_flag("chain busy on", 1'b1, busy_enabled);
	endtask

	// ------------------------------------------------------------------
	// Clock, main sequence, watchdog
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Back to back conversions, mode changing every time except from sc_sel_plain to sc_sel_short
	initial begin
		err_total = 0;
		n_checks  = 0;
		rst       = 1'b1;
		start     = 1'b0;
		chain_sel = 1'b0;
		busy_sel  = 1'b0;
		bit_count = 8'h00;
		code      = 14'h0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		sc_sel_plain();
		sc_sel_short();
		sc_sel_busy();
		sc_chain_plain();
		sc_chain_busy();
		sc_sel_plain();
		stop_test();
	end

	// Generous bound over the roughly 1000 cycles the tests need
	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		stop_test();
	end
endmodule // tb_adcrd_serial_readout_chain

`default_nettype wire
